// >>> hw/rsa_slave.sv
`timescale 1ns/1ps
// Contract
// - Address LSB one reads, zero writes.
// - Acknowledge only when identifier matches either space.
// - One word-address byte follows, else counter used.
// - Pointer clears to zero at reset.
// - Acknowledge every write byte; STOP returns standby.
// - Send bytes while master acknowledges ninth clock.
// - Pointer starts at address, increments per byte.
// - Pointer wraps to zero after location 13h in register space, after 7Fh in user memory.
// - START/STOP change data while clock high.
// - Bytes travel most significant bit first.
module rsa_slave #(
  parameter logic [6:0] ID_REG = 7'h21,  // Arbitrary identifier of the register space.
  parameter logic [6:0] ID_USR = 7'h22   // Arbitrary identifier of the user memory space.
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output wire logic                       sda_out,
  output wire logic                       sda_oe_out,
  output wire logic [rsa_pkg::BYTE_W-1:0] addr_out,
  output wire logic                       space_usr_out,
  input  wire logic [rsa_pkg::BYTE_W-1:0] rd_data_in,
  output wire logic                       wr_stb_out,
  output wire logic [rsa_pkg::BYTE_W-1:0] wr_addr_out,
  output wire logic [rsa_pkg::BYTE_W-1:0] wr_data_out
);
  import rsa_pkg::*;

  // ============================================================
  // Elaboration checks
  // ============================================================
  // Two equal identifiers would make the space choice ambiguous.
  if (ID_REG == ID_USR) begin : g_id_check
    $error("rsa_slave: the two identifiers must differ");
  end

  // ============================================================
  // Helper functions
  // ============================================================
  // True when the upper seven bits of a byte equal an identifier.
  function automatic logic id_match(input logic [7:0] b, input logic [6:0] id);
    id_match = (b[7:1] == id);
  endfunction

  // Next pointer value, wrapping at the last location of the space.
  function automatic logic [7:0] ptr_inc(input logic [7:0] p, input logic usr);
    logic [7:0] last;
    last    = usr ? USR_LAST : REG_LAST;
    ptr_inc = (p == last) ? PTR_WRAP : p + 8'h01;
  endfunction

  // ============================================================
  // Pin synchronisers and bus event detection
  // ============================================================
  logic scl_m_r, scl_s_r, scl_d_r;  // Clock line: meta, stable, delayed.
  logic sda_m_r, sda_s_r, sda_d_r;  // Data line: meta, stable, delayed.
  // Three flip-flops per pin; the meta stage never feeds logic. Resetting to the
  // idle level keeps a false START or STOP from following reset.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      {scl_m_r, scl_s_r, scl_d_r} <= {3{BUS_IDLE}};
      {sda_m_r, sda_s_r, sda_d_r} <= {3{BUS_IDLE}};
    end else begin
      {scl_d_r, scl_s_r, scl_m_r} <= {scl_s_r, scl_m_r, scl_in};
      {sda_d_r, sda_s_r, sda_m_r} <= {sda_s_r, sda_m_r, sda_in};
    end
  end
  logic rise, fall, start_ev, stop_ev;  // One-cycle bus events.
  assign rise     = scl_s_r & ~scl_d_r;
  assign fall     = ~scl_s_r & scl_d_r;
  // Data edges with the clock held high mark frame boundaries.
  assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ============================================================
  // Protocol engine
  // ============================================================
  rsa_state_e st_r, st_nxt;              // Engine state.
  rsa_phase_e ph_r, ph_nxt;              // Received byte role.
  logic [7:0] sh_r, sh_nxt;              // Shift register, both directions.
  logic [2:0] cnt_r, cnt_nxt;            // Bit counter within a byte.
  logic       done_r, done_nxt;          // Eighth bit has passed.
  logic       oe_r, oe_nxt;              // Pulling the data line low.
  logic [7:0] ptr_r, ptr_nxt;            // Auto-incrementing address pointer.
  logic       usr_r, usr_nxt;            // Selected space: user memory when set.
  logic       rd_go_r, rd_go_nxt;        // Direction bit of the last match.
  logic       mack_r, mack_nxt;          // Master acknowledged the last byte.
  logic       wr_stb_r, wr_stb_nxt;      // Write strobe.
  logic [7:0] wr_data_r, wr_data_nxt;    // Written byte.
  logic [7:0] wr_addr_r, wr_addr_nxt;    // Address of the written byte.
  logic       id_hit;                    // Either identifier matches.
  assign id_hit = id_match(sh_r, ID_REG) | id_match(sh_r, ID_USR);
  // Next-state logic. Bits are sampled on clock rise and driven after fall,
  // so the line never moves while the clock is high.
  always_comb begin
    st_nxt      = st_r;
    ph_nxt      = ph_r;
    sh_nxt      = sh_r;
    cnt_nxt     = cnt_r;
    ptr_nxt     = ptr_r;
    {done_nxt, oe_nxt, usr_nxt, rd_go_nxt, mack_nxt} = {done_r, oe_r, usr_r, rd_go_r, mack_r};
    wr_stb_nxt  = 1'b0;
    {wr_data_nxt, wr_addr_nxt} = {wr_data_r, wr_addr_r};
    if (start_ev) begin
      // A START, repeated or not, always restarts address decoding.
      st_nxt   = ST_RX;
      ph_nxt   = PH_DEV;
      cnt_nxt  = 3'h0;
      done_nxt = 1'b0;
      oe_nxt   = 1'b0;
    end else if (stop_ev) begin
      // STOP puts the interface in standby; the pointer is kept.
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_RX: begin
          if (rise && !done_r) begin
            sh_nxt  = {sh_r[6:0], sda_s_r};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == BIT_LAST) begin
              done_nxt = 1'b1;
            end
          end else if (fall && done_r) begin
            done_nxt = 1'b0;
            cnt_nxt  = 3'h0;
            case (ph_r)
              PH_DEV: begin
                if (id_hit) begin
                  st_nxt    = ST_RX_ACK;
                  oe_nxt    = 1'b1;
                  usr_nxt   = id_match(sh_r, ID_USR);
                  rd_go_nxt = sh_r[0];
                  ph_nxt    = PH_WORD;
                end else begin
                  st_nxt = ST_IDLE;
                end
              end
              PH_WORD: begin
                ptr_nxt   = sh_r;
                st_nxt    = ST_RX_ACK;
                oe_nxt    = 1'b1;
                ph_nxt    = PH_DATA;
              end
              default: begin
                // Data byte: store it and acknowledge.
                wr_stb_nxt  = 1'b1;
                wr_data_nxt = sh_r;
                wr_addr_nxt = ptr_r;
                ptr_nxt     = ptr_inc(ptr_r, usr_r);
                st_nxt      = ST_RX_ACK;
                oe_nxt      = 1'b1;
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          if (fall) begin
            if (rd_go_r) begin
              // Read chosen: first bit follows the acknowledge directly.
              st_nxt = ST_TX;
              sh_nxt = rd_data_in;
              oe_nxt = ~rd_data_in[7];
            end else begin
              st_nxt = ST_RX;
              oe_nxt = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (rise && !done_r) begin
            sh_nxt  = {sh_r[6:0], 1'b0};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == BIT_LAST) begin
              done_nxt = 1'b1;
            end
          end else if (fall) begin
            if (done_r) begin
              done_nxt = 1'b0;
              cnt_nxt  = 3'h0;
              oe_nxt   = 1'b0;
              st_nxt   = ST_TX_ACK;
              ptr_nxt  = ptr_inc(ptr_r, usr_r);
            end else begin
              oe_nxt = ~sh_r[7];
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            mack_nxt = ~sda_s_r;
          end else if (fall) begin
            if (mack_r) begin
              st_nxt = ST_TX;
              sh_nxt = rd_data_in;
              oe_nxt = ~rd_data_in[7];
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          // Idle ignores everything except START.
          oe_nxt = 1'b0;
        end
      endcase
    end
  end
  // State registers; a synchronous reset doubles as power-up.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_r      <= ST_IDLE;
      ph_r      <= PH_DEV;
      sh_r      <= 8'h00;
      cnt_r     <= 3'h0;
      ptr_r     <= PTR_RST;
      {done_r, oe_r, usr_r, rd_go_r, mack_r, wr_stb_r} <= 6'h00;
      {wr_data_r, wr_addr_r} <= 16'h0000;
    end else begin
      st_r      <= st_nxt;
      ph_r      <= ph_nxt;
      sh_r      <= sh_nxt;
      cnt_r     <= cnt_nxt;
      ptr_r     <= ptr_nxt;
      {done_r, oe_r, usr_r, rd_go_r, mack_r, wr_stb_r} <= {done_nxt, oe_nxt, usr_nxt, rd_go_nxt,
                                                          mack_nxt, wr_stb_nxt};
      {wr_data_r, wr_addr_r} <= {wr_data_nxt, wr_addr_nxt};
    end
  end
  // Open-drain line: only ever pulled low.
  assign sda_out       = 1'b0;
  assign sda_oe_out    = oe_r;
  assign addr_out      = ptr_r;
  assign space_usr_out = usr_r;
  assign wr_stb_out    = wr_stb_r;
  assign wr_addr_out   = wr_addr_r;
  assign wr_data_out   = wr_data_r;

  // ============================================================
  // Assertions
  // ============================================================
  logic rd_msb;  // Helper for the first transmitted bit.
  assign rd_msb = rd_data_in[7];
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  ack_on_match_a: assert property (
    (st_r == ST_RX && ph_r == PH_DEV && done_r && fall && id_hit && !start_ev && !stop_ev)
      |=> (st_r == ST_RX_ACK && oe_r))
    else $error("matched identifier not acknowledged");
  miss_release_a: assert property (
    (st_r == ST_RX && ph_r == PH_DEV && done_r && fall && !id_hit && !start_ev && !stop_ev)
      |=> (st_r == ST_IDLE && !oe_r) [*2])
    else $error("mismatch did not release the line");
  ptr_reset_a: assert property (@(posedge clk_sys_in) disable iff (1'b0)
    sys_rst_in |=> (ptr_r == PTR_RST))
    else $error("pointer not cleared by reset");
  ptr_wrap_a: assert property (
    (st_r == ST_TX && done_r && fall && !rise && ptr_r == REG_LAST && !usr_r
      && !start_ev && !stop_ev) |=> (ptr_r == PTR_WRAP))
    else $error("pointer did not wrap after last register");
  ptr_step_a: assert property (
    (st_r == ST_TX && done_r && fall && ptr_r != REG_LAST && ptr_r != USR_LAST
      && !start_ev && !stop_ev) |=> (ptr_r == $past(ptr_r) + 8'h01))
    else $error("pointer did not step by one");
  stop_standby_a: assert property (
    (stop_ev && !start_ev) |=> (st_r == ST_IDLE && !oe_r))
    else $error("stop did not return to standby");
  read_msb_a: assert property (
    (st_r == ST_RX_ACK && fall && rd_go_r && !start_ev && !stop_ev)
      |=> (st_r == ST_TX && oe_r == !$past(rd_msb)))
    else $error("read did not begin with the top bit");
  write_sel_a: assert property (
    (st_r == ST_RX_ACK && fall && !rd_go_r && !start_ev && !stop_ev)
      |=> (st_r == ST_RX && !oe_r))
    else $error("write direction did not return to receive");
  nack_end_a: assert property (
    (st_r == ST_TX_ACK && fall && !mack_r && !start_ev && !stop_ev) |=> (st_r == ST_IDLE))
    else $error("transmit continued without acknowledge");
  strobe_once_a: assert property (
    wr_stb_r |=> !wr_stb_r ##1 !wr_stb_r)
    else $error("write strobe longer than one cycle");

  write_done_c: cover property (wr_stb_r ##[1:1000] stop_ev);
  read_more_c:  cover property ((st_r == ST_TX_ACK && fall && mack_r) ##1 st_r == ST_TX);
  miss_c:       cover property (st_r == ST_RX && ph_r == PH_DEV && done_r && fall && !id_hit);
  wrap_c:       cover property (st_r == ST_TX_ACK && ptr_r == PTR_WRAP && !usr_r);
endmodule

// >>> hw/rsa_pkg.sv
// ============================================================
// Shared constants and types for the serial slave front end.
// ============================================================
package rsa_pkg;

  // Width of every byte on the bus.
  localparam int unsigned BYTE_W   = 8;
  // Index of the last bit of a byte in the bit counter.
  localparam logic [2:0]  BIT_LAST = 3'h7;
  // Pointer value after reset, so a current-address read starts here.
  localparam logic [7:0]  PTR_RST  = 8'h00;
  // Last pointer location of the clock register space before it wraps.
  localparam logic [7:0]  REG_LAST = 8'h13;
  // Last pointer location of the user memory space before it wraps.
  localparam logic [7:0]  USR_LAST = 8'h7f;
  // Pointer value after a wrap.
  localparam logic [7:0]  PTR_WRAP = 8'h00;
  // Idle level of both bus lines, used for the synchroniser reset.
  localparam logic        BUS_IDLE = 1'b1;

  // Protocol engine states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } rsa_state_e;

  // Which received byte of a transaction is being shifted in.
  typedef enum logic [1:0] {
    PH_DEV,
    PH_WORD,
    PH_DATA
  } rsa_phase_e;

endpackage

// >>> verif/rsa_master.sv
`timescale 1ns/1ps
// ============================================================
// Bus master model: it drives the clock line and pulls data low.
// ============================================================
module rsa_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // The bus idles with both lines high, and the clock stands still between frames.
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // Waits a number of system clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // START or repeated START: data falls only while the clock is high.
  task automatic start();
    sda_oe_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_oe_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
    tick(2);
  endtask

  // STOP: data rises while the clock is high, leaving the bus idle.
  task automatic stop();
    sda_oe_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_oe_out <= 1'b0;
    tick(4);
  endtask

  // One bit: data changes in the low phase, sampled late in the high phase.
  task automatic send_bit(input logic b, output logic r);
    sda_oe_out <= ~b;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    r = sda_in;
    scl_out <= 1'b0;
    tick(2);
  endtask

  // Eight bits most significant first, then the acknowledge clock.
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                      output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i], r);
      q[i] = r;
    end
    send_bit(ak, r);
    acked = ~r;
  endtask
endmodule

// >>> verif/rsa_slave_bench.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the serial slave front end.
// ============================================================
module rsa_slave_bench;
  import rsa_pkg::*;
  localparam logic [6:0] ID_R = 7'h21; // Arbitrary register space identifier.
  localparam logic [6:0] ID_U = 7'h22; // Arbitrary user space identifier.
  logic       clk, rst, scl, m_oe, sda_oe, sda_dev, space_usr, wr_stb;
  logic [7:0] addr, wr_addr, wr_data, rd_data;
  // Pulled up; the enabled device puts its data output on the line, so a device that
  // drove high instead of low would lose every acknowledge and every low read bit.
  wire        sda = ~m_oe & (~sda_oe | sda_dev);
  int         num_errors, total_checks, oe_cnt;
  logic [16:0] wq[$]; // Writes seen as {space, address, data}.

  // Memory contents differ per space so a wrong space shows up; the top address
  // bit flips the low bit, so a pointer that misses its wrap shows up as well.
  function automatic logic [7:0] mem(input logic s, input logic [7:0] a);
    return {a[6:0], s ^ a[7]} ^ 8'h96;
  endfunction
  assign rd_data = mem(space_usr, addr);

  rsa_slave #(.ID_REG(ID_R), .ID_USR(ID_U)) uut (
    .clk_sys_in(clk), .sys_rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_dev),
    .sda_oe_out(sda_oe), .addr_out(addr), .space_usr_out(space_usr),
    .rd_data_in(rd_data), .wr_stb_out(wr_stb), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data));
  rsa_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

  // The 50 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Records every write strobe and counts cycles with data pulled by the device.
  always @(posedge clk) begin
    if (wr_stb === 1'b1) wq.push_back({space_usr, wr_addr, wr_data});
    if (sda_oe === 1'b1) oe_cnt++;
  end

  // Compares one value and reports a difference at once.
  task automatic check(input string nm, input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // START plus identifier byte, judging the device acknowledge.
  task automatic hdr(input logic [6:0] id, input logic rw, input logic exp);
    logic [7:0] q;
    logic a;
    m.start();
    m.xfer({id, rw}, 1'b1, q, a);
    check("id ack", 17'(a), 17'(exp));
  endtask

  // Written byte, which the device must acknowledge.
  task automatic wbyte(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    m.xfer(d, 1'b1, q, a);
    check("byte ack", 17'(a), 17'h1);
  endtask

  // Read byte, then the master acknowledge or not.
  task automatic rbyte(input logic ak, input logic [7:0] exp);
    logic [7:0] q;
    logic a;
    m.xfer(8'hff, ak, q, a);
    check("read data", 17'(q), 17'(exp));
  endtask

  // Current address read straight after reset starts at location zero.
  task automatic t_cur();
    hdr(ID_U, 1'b1, 1'b1);
    rbyte(1'b1, mem(1'b1, 8'h00));
    m.stop();
    $display("test current read done");
  endtask

  // Two data bytes written back to back land at consecutive addresses.
  task automatic t_write();
    wq.delete();
    hdr(ID_R, 1'b0, 1'b1);
    wbyte(8'h05);
    wbyte(8'ha6);
    wbyte(8'h3c);
    m.stop();
    check("write count", 17'(wq.size()), 17'h2);
    check("write one", wq[0], {1'b0, 8'h05, 8'ha6});
    check("write two", wq[1], {1'b0, 8'h06, 8'h3c});
    $display("test write done");
  endtask

  // Random register read across the wrap point.
  task automatic t_rand();
    hdr(ID_R, 1'b0, 1'b1);
    wbyte(8'h12);
    hdr(ID_R, 1'b1, 1'b1);
    rbyte(1'b0, mem(1'b0, 8'h12));
    rbyte(1'b0, mem(1'b0, 8'h13));
    rbyte(1'b1, mem(1'b0, 8'h00));
    m.stop();
    $display("test random read done");
  endtask

  // User space write and read; location 13h does not wrap there.
  task automatic t_user();
    wq.delete();
    hdr(ID_U, 1'b0, 1'b1);
    wbyte(8'h40);
    wbyte(8'h81);
    m.stop();
    check("user write", wq[0], {1'b1, 8'h40, 8'h81});
    hdr(ID_U, 1'b0, 1'b1);
    wbyte(8'h13);
    hdr(ID_U, 1'b1, 1'b1);
    rbyte(1'b0, mem(1'b1, 8'h13));
    rbyte(1'b1, mem(1'b1, 8'h14));
    // The user space runs on to its own last location before it wraps.
    hdr(ID_U, 1'b0, 1'b1);
    wbyte(USR_LAST);
    hdr(ID_U, 1'b1, 1'b1);
    rbyte(1'b0, mem(1'b1, USR_LAST));
    rbyte(1'b1, mem(1'b1, PTR_WRAP));
    m.stop();
    $display("test user space done");
  endtask

  // Identifier one bit off: no acknowledge, no drive, no write.
  task automatic t_nomatch();
    logic [7:0] q;
    logic a;
    wq.delete();
    oe_cnt = 0;
    hdr({ID_R[6:1], ~ID_R[0]}, 1'b0, 1'b0);
    m.xfer(8'h00, 1'b1, q, a);
    check("ignored ack", 17'(a), 17'h0);
    m.stop();
    check("drive count", 17'(oe_cnt), 17'h0);
    check("ignored writes", 17'(wq.size()), 17'h0);
    $display("test mismatch done");
  endtask

  // Main sequence: reset for 16 cycles, then every scenario in turn.
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_cur();
    t_write();
    t_rand();
    t_user();
    t_nomatch();
    results();
  end

  // Watchdog: the scenarios need about 2150 cycles, so a clean run ends well before this.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule
